// ### rtl/ilp_pkg.sv
// constants for the interrupt log and pending-flag block
// assumes a 16-bit word-addressed host register port and a 100 MHz core clock
package ilp_pkg;
    // register word offsets
    localparam logic [15:0] ILP_HW_PEND_OFS = 16'h0006;
    localparam logic [15:0] ILP_RT_PEND_OFS = 16'h0009;
    localparam logic [15:0] ILP_CNTPTR_OFS = 16'h000A;
    localparam logic [15:0] ILP_HW_EN_OFS = 16'h000F;
    localparam logic [15:0] ILP_HW_OE_OFS = 16'h0013;
    // field positions and widths
    localparam int ILP_TERMINAL_FLAGS_NONZERO_BIT = 2;
    localparam int ILP_CNT_LSB = 9;
    localparam logic [6:0] ILP_CNT_MAX = 7'h7F;
    localparam logic [2:0] ILP_PTR_HI = 3'h6;
    localparam logic [15:0] ILP_HW_EV_MASK = 16'hFFF8;
    // reset values
    localparam logic [15:0] ILP_CNTPTR_RST = 16'h0180;
    localparam logic [15:0] ILP_HW_EN_RST = 16'hE008;
    localparam logic [15:0] ILP_HW_OE_RST = 16'h0000;
    localparam logic [15:0] ILP_LOG_BASE = 16'h0180;
    localparam logic [15:0] ILP_IAW_ZERO = 16'h0000;
    // saturating increment shared by the counter
    function automatic logic [6:0] ilp_sat_inc(input logic [6:0] v);
        return (v == ILP_CNT_MAX) ? v : v + 7'h01;
    endfunction
endpackage

// ### rtl/ilp_log_ptr.sv
// count and log pointer keeper for the interrupt log buffer
// assumes one log event pulse per accepted interrupt group
`timescale 1ns/1ps
`default_nettype none
module ilp_log_ptr
    import ilp_pkg::*;
(
    // clock and master reset
    input wire logic core_clk_i,
    input wire logic rst_i,
    // events
    input wire logic log_i,
    input wire logic rd_clr_i,
    // state
    output logic [15:0] cntptr_o
);
    logic [6:0] cnt_r;
    logic [5:0] slot_r;
    logic [6:0] cnt_nxt;

    // read clears count; an event in the same cycle still counts
    assign cnt_nxt = log_i ? (rd_clr_i ? 7'h01 : ilp_sat_inc(cnt_r))
                           : (rd_clr_i ? 7'h00 : cnt_r);

    // only master reset touches these, never the terminal soft reset
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            cnt_r <= 7'h00;
            slot_r <= 6'h00;
        end else begin
            cnt_r <= cnt_nxt;
            if (log_i) begin
                slot_r <= slot_r + 6'h01; // low five bits wrap after 32nd pair; slot_r itself after 64th
            end
        end
    end

    // pointer even, bits 8:6 fixed
    assign cntptr_o = {cnt_r, ILP_PTR_HI, slot_r[4:0], 1'b0};

    a_count_saturates: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (cnt_r == ILP_CNT_MAX && log_i && !rd_clr_i) |=> cnt_r == ILP_CNT_MAX)
        else $error("count left saturation");
    a_ptr_advances: assert property (@(posedge core_clk_i) disable iff (rst_i)
        log_i |=> cntptr_o[5:1] == $past(cntptr_o[5:1]) + 5'h01)
        else $error("pointer did not advance by one pair");
    a_ptr_holds_read: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (rd_clr_i && !log_i) |=> cntptr_o[8:0] == $past(cntptr_o[8:0]) && cntptr_o[15:9] == 7'h00)
        else $error("read changed pointer or kept count");
endmodule
`default_nettype wire

// ### rtl/ilp_irq_log.sv
// interrupt pending flags, enables, output gating and log writer
// assumes host register strobes and event pulses are synchronous to core_clk_i
//
// Behaviour
// - disabled events leave no trace at all
// - enabling later ignores earlier events
// - enabled hardware event logs and sets pending
// - reading hardware pending clears it
// - output-enabled pending events assert the interrupt
// - one interrupt line ORs both groups
// - bit 2 shows terminal flags nonzero
// - reading terminal pending clears it
// - count logged interrupts, saturating at 127
// - reading count register clears only count
// - count register read-only, resets to 0x0180
// - terminal soft reset leaves count register
// - pointer even, bits 8:6 fixed 110
// - pointer gives next pair address
// - pointer wraps after 32nd entry
// - four hardware enables set after reset
// - concurrent interrupts give one log update
// - hardware address word zero unless parity
`timescale 1ns/1ps
`default_nettype none
module ilp_irq_log
    import ilp_pkg::*;
(
    // clock and master reset
    input wire logic core_clk_i,
    input wire logic rst_i,
    // host register port
    input wire logic [15:0] reg_addr_i,
    input wire logic reg_rd_i,
    input wire logic reg_wr_i,
    input wire logic [15:0] reg_wdata_i,
    output logic [15:0] reg_rdata_o,
    // terminal group, kept by the terminal logic
    input wire logic terminal_soft_reset_i,
    input wire logic [15:0] rt_event_i,
    input wire logic [15:0] rt_enable_i,
    input wire logic [15:0] rt_out_enable_i,
    input wire logic [15:0] rt_desc_addr_i,
    // hardware events
    input wire logic [15:0] hw_event_i,
    input wire logic ram_parity_fail_i,
    input wire logic [15:0] ram_parity_addr_i,
    // log buffer write port
    output logic log_we_o,
    output logic [15:0] log_addr_o,
    output logic [15:0] log_data_o,
    // host interrupt, active low
    output logic irq_n_o
);
    logic [15:0] hw_pend_r;
    logic [15:0] rt_pend_r;
    logic [15:0] hw_en_r;
    logic [15:0] hw_oe_r;
    logic [15:0] iaw_r;
    logic [15:0] cntptr;
    logic [15:0] rd_data_r;
    logic log_we_r;
    logic log_phase_r;
    logic [15:0] log_addr_r;
    logic [15:0] log_data_r;
    logic irq_n_r;

    // hazard: the parity bit must be an enabled hardware event too
    logic [15:0] hw_ev_all;
    logic [15:0] hw_hit;
    logic [15:0] rt_hit;
    logic [15:0] log_identification_word;
    logic rd_hw;
    logic rd_rt;
    logic rd_cnt;
    logic wr_en;
    logic wr_oe;
    logic log_ev;
    logic [15:0] hw_pend_nxt;
    logic [15:0] rt_pend_nxt;
    logic irq_nxt;
    logic [15:0] rd_mux;
    logic [15:0] hw_oe_nxt;

    // register decode
    assign rd_hw = reg_rd_i && (reg_addr_i == ILP_HW_PEND_OFS);
    assign rd_rt = reg_rd_i && (reg_addr_i == ILP_RT_PEND_OFS);
    assign rd_cnt = reg_rd_i && (reg_addr_i == ILP_CNTPTR_OFS);
    assign wr_en = reg_wr_i && (reg_addr_i == ILP_HW_EN_OFS);
    assign wr_oe = reg_wr_i && (reg_addr_i == ILP_HW_OE_OFS);

    // events gated by the current enables only; no memory of masked ones
    assign hw_ev_all = hw_event_i & ILP_HW_EV_MASK;
    assign hw_hit = hw_ev_all & hw_en_r;
    assign rt_hit = rt_event_i & rt_enable_i & ILP_HW_EV_MASK;

    // one log entry per cycle covering all concurrent hits
    assign log_ev = |hw_hit || |rt_hit;
    assign log_identification_word = hw_hit | rt_hit | {13'h0000, |rt_hit, 2'b00};

    // set wins over the read clear
    assign hw_pend_nxt = (rd_hw ? 16'h0000 : hw_pend_r) | hw_hit;
    assign rt_pend_nxt = (rd_rt ? 16'h0000 : rt_pend_r) | rt_hit;

    // output enable as it stands after this edge, so a write and the line agree
    assign hw_oe_nxt = wr_oe ? (reg_wdata_i & ILP_HW_EV_MASK) : hw_oe_r;

    // one line shared by both groups
    assign irq_nxt = |(hw_pend_nxt & hw_oe_nxt) || |(rt_pend_nxt & rt_out_enable_i);

    // read mux; bit 2 is live terminal status
    assign rd_mux = rd_hw ? {hw_pend_r[15:3], |rt_pend_r, 2'b00} :
                    rd_rt ? rt_pend_r :
                    rd_cnt ? cntptr :
                    (reg_addr_i == ILP_HW_EN_OFS) ? hw_en_r :
                    (reg_addr_i == ILP_HW_OE_OFS) ? hw_oe_r : 16'h0000;

    ilp_log_ptr u_ptr (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .log_i(log_ev),
        .rd_clr_i(rd_cnt),
        .cntptr_o(cntptr)
    );

    // enables and output enables; master reset only
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            hw_en_r <= ILP_HW_EN_RST;
            hw_oe_r <= ILP_HW_OE_RST;
        end else begin
            if (wr_en) begin
                hw_en_r <= reg_wdata_i & ILP_HW_EV_MASK;
            end
            if (wr_oe) begin
                hw_oe_r <= reg_wdata_i & ILP_HW_EV_MASK;
            end
        end
    end

    // pending flags; terminal soft reset clears terminal flags only
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            hw_pend_r <= 16'h0000;
            rt_pend_r <= 16'h0000;
        end else begin
            hw_pend_r <= hw_pend_nxt;
            rt_pend_r <= terminal_soft_reset_i ? rt_hit : rt_pend_nxt;
        end
    end

    // read data and interrupt line registered
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            rd_data_r <= 16'h0000;
            irq_n_r <= 1'b1;
        end else begin
            if (reg_rd_i) begin
                rd_data_r <= rd_mux;
            end
            irq_n_r <= ~irq_nxt;
        end
    end

    // two-word log write: identification word, then address word
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            log_we_r <= 1'b0;
            log_phase_r <= 1'b0;
            log_addr_r <= ILP_LOG_BASE;
            log_data_r <= 16'h0000;
            iaw_r <= ILP_IAW_ZERO;
        end else if (log_ev) begin
            log_we_r <= 1'b1;
            log_phase_r <= 1'b1;
            log_addr_r <= {7'h00, cntptr[8:0]};
            log_data_r <= log_identification_word;
            iaw_r <= |rt_hit ? rt_desc_addr_i :
                     (hw_hit[15:3] == 13'h0000) ? ILP_IAW_ZERO :
                     (ram_parity_fail_i ? ram_parity_addr_i : ILP_IAW_ZERO);
        end else if (log_phase_r) begin
            log_we_r <= 1'b1;
            log_phase_r <= 1'b0;
            log_addr_r <= log_addr_r + 16'h0001;
            log_data_r <= iaw_r;
        end else begin
            log_we_r <= 1'b0;
        end
    end

    assign reg_rdata_o = rd_data_r;
    assign log_we_o = log_we_r;
    assign log_addr_o = log_addr_r;
    assign log_data_o = log_data_r;
    assign irq_n_o = irq_n_r;

    a_masked_no_pend: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (hw_pend_r == 16'h0000 && hw_hit == 16'h0000 && rt_hit == 16'h0000)
        |=> hw_pend_r == 16'h0000 && !(log_we_o && !log_addr_o[0]))
        else $error("masked event left a trace");
    a_hw_event_pend: assert property (@(posedge core_clk_i) disable iff (rst_i)
        |hw_hit |=> (hw_pend_r & $past(hw_hit)) == $past(hw_hit) && log_we_o)
        else $error("enabled event not latched or logged");
    a_hw_read_clr: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (rd_hw && hw_hit == 16'h0000) |=> hw_pend_r == 16'h0000)
        else $error("hardware pending not cleared by read");
    a_rt_read_clr: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (rd_rt && rt_hit == 16'h0000 && !terminal_soft_reset_i) |=> rt_pend_r == 16'h0000)
        else $error("terminal pending not cleared by read");
    a_terminal_flags_nonzero_read: assert property (@(posedge core_clk_i) disable iff (rst_i)
        rd_hw |=> reg_rdata_o[ILP_TERMINAL_FLAGS_NONZERO_BIT] == ($past(rt_pend_r) != 16'h0000))
        else $error("bit 2 wrong");
    a_irq_follows: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (|(hw_pend_r & hw_oe_r)) |-> !irq_n_o || $past(rst_i))
        else $error("interrupt not driven for enabled pending");
    a_log_pair: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (log_ev && !log_phase_r) |=> log_we_o ##1 (log_we_o && log_addr_o[0]))
        else $error("log pair not written");
    a_hw_iaw_zero: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (log_ev && rt_hit == 16'h0000 && !ram_parity_fail_i) ##1 !log_ev |=>
        log_data_o == ILP_IAW_ZERO)
        else $error("hardware address word not zero");

    // guards on the interrupt line, reset values, pointer and log words

    // an output-enabled hardware hit pulls the line next cycle
    a_irq_hw_group: assert property (@(posedge core_clk_i) disable iff (rst_i)
        |(hw_hit & hw_oe_nxt) |=> !irq_n_o)
        else $error("hardware hit did not assert interrupt");

    // an output-enabled terminal hit pulls the same line
    a_irq_rt_group: assert property (@(posedge core_clk_i) disable iff (rst_i)
        |(rt_hit & rt_out_enable_i) |=> !irq_n_o)
        else $error("terminal hit did not assert interrupt");

    // line is low while any enabled condition is pending
    a_irq_low_level: assert property (@(posedge core_clk_i) disable iff (rst_i)
        irq_nxt |=> !irq_n_o)
        else $error("interrupt not low while pending");

    // line returns high once nothing enabled is pending
    a_irq_released: assert property (@(posedge core_clk_i) disable iff (rst_i)
        !irq_nxt |=> irq_n_o)
        else $error("interrupt stayed low after clear");

    // polled-only hits latch but leave the line alone
    a_polled_no_irq: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (|hw_hit && (hw_pend_nxt & hw_oe_nxt) == 16'h0000
         && (rt_pend_nxt & rt_out_enable_i) == 16'h0000) |=> irq_n_o)
        else $error("polled event asserted interrupt");

    // four hardware enables preset out of master reset
    a_enable_reset: assert property (@(posedge core_clk_i) disable iff (rst_i)
        $fell(rst_i) |-> hw_en_r == ILP_HW_EN_RST)
        else $error("enable reset value wrong");

    // count register starts at buffer base with zero count
    a_cntptr_reset: assert property (@(posedge core_clk_i) disable iff (rst_i)
        $fell(rst_i) |-> cntptr == ILP_CNTPTR_RST)
        else $error("count register reset value wrong");

    // line idle high out of reset
    a_irq_reset_high: assert property (@(posedge core_clk_i) disable iff (rst_i)
        $fell(rst_i) |-> irq_n_o)
        else $error("interrupt low after reset");

    // terminal soft reset leaves count and pointer alone
    a_soft_rst_keeps: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (terminal_soft_reset_i && !log_ev && !rd_cnt) |=> cntptr == $past(cntptr))
        else $error("soft reset changed count register");

    // pointer always even inside the fixed window
    a_ptr_fixed_bits: assert property (@(posedge core_clk_i) disable iff (rst_i)
        cntptr[8:6] == ILP_PTR_HI && !cntptr[0])
        else $error("pointer outside buffer window");

    // first word of an entry lands where the pointer said
    a_log_at_ptr: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (log_ev && !log_phase_r) |=> log_addr_o == {7'h00, $past(cntptr[8:0])})
        else $error("entry not written at pointer");

    // every log write stays inside the circular buffer
    a_log_in_buffer: assert property (@(posedge core_clk_i) disable iff (rst_i)
        log_we_o |-> log_addr_o[15:6] == ILP_LOG_BASE[15:6])
        else $error("log write outside buffer");

    // count steps by one per entry below saturation
    a_count_incr: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (log_ev && !rd_cnt && cntptr[15:9] != ILP_CNT_MAX)
        |=> cntptr[15:9] == $past(cntptr[15:9]) + 7'h01)
        else $error("count did not step");

    // read clear and entry in one cycle leave a count of one
    a_count_read_event: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (rd_cnt && log_ev) |=> cntptr[15:9] == 7'h01)
        else $error("count lost entry during read");

    // terminal entries flag bit 2 in the identification word
    a_rt_log_terminal_flags_nonzero: assert property (@(posedge core_clk_i) disable iff (rst_i)
        |rt_hit |=> log_we_o && log_data_o[ILP_TERMINAL_FLAGS_NONZERO_BIT])
        else $error("terminal entry missing bit 2");

    // identification word carries every concurrent hit
    a_iiw_hits: assert property (@(posedge core_clk_i) disable iff (rst_i)
        log_ev |=> log_data_o[15:3] == ($past(hw_hit[15:3]) | $past(rt_hit[15:3])))
        else $error("identification word missing hits");

    // hardware pending never holds the low three bits
    a_hw_pend_bits: assert property (@(posedge core_clk_i) disable iff (rst_i)
        hw_pend_r[2:0] == 3'b000)
        else $error("hardware pending low bits set");

    // masked terminal events set nothing
    a_rt_masked: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (rt_pend_r == 16'h0000 && rt_hit == 16'h0000) |=> rt_pend_r == 16'h0000)
        else $error("masked terminal event latched");
endmodule
`default_nettype wire

// ### test/ilp_host_model.sv
// host processor model driving the register port
// assumes strobes taken on the rising edge, read data one cycle later
`timescale 1ns/1ps
`default_nettype none
module ilp_host_model (
    // clock
    input wire logic core_clk_i,
    // register port
    output logic [15:0] reg_addr_o,
    output logic reg_rd_o,
    output logic reg_wr_o,
    output logic [15:0] reg_wdata_o,
    input wire logic [15:0] reg_rdata_i
);
    // idle bus at time zero
    initial begin
        reg_addr_o = 16'h0000;
        reg_rd_o = 1'b0;
        reg_wr_o = 1'b0;
        reg_wdata_o = 16'h0000;
    end
    // one write strobe, then the bus shows inverted junk
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge core_clk_i) #1;
        reg_addr_o = a;
        reg_wdata_o = d;
        reg_wr_o = 1'b1;
        @(posedge core_clk_i) #1;
        reg_wr_o = 1'b0;
        reg_addr_o = ~a;
        reg_wdata_o = ~d;
    endtask
    // one read strobe; the value is kept, a reread of a clear-on-read register would not return it
    task automatic rd(input logic [15:0] a, output logic [15:0] d);
        @(posedge core_clk_i) #1;
        reg_addr_o = a;
        reg_rd_o = 1'b1;
        @(posedge core_clk_i) #1;
        reg_rd_o = 1'b0;
        reg_addr_o = ~a;
        d = reg_rdata_i;
    endtask
endmodule
`default_nettype wire

// ### test/ilp_irq_log_tb_top.sv
// testbench for the interrupt log and pending-flag block
// assumes the host model drives the register port
`timescale 1ns/1ps
`default_nettype none
module ilp_irq_log_tb_top
    import ilp_pkg::*;
;
    logic core_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [15:0] addr, wd, rdat, hw_ev, rt_ev, rt_en, rt_oe, rt_da, pa, la, ld, v;
    logic rd, wr, srst, pf, we, irq_n;
    logic [15:0] ptr = 16'h0180;
    int fail_count = 0;
    int cmp_count = 0;
    // 100 MHz clock
    always #5 core_clk_i = ~core_clk_i;
    ilp_host_model u_host (.core_clk_i(core_clk_i), .reg_addr_o(addr), .reg_rd_o(rd),
        .reg_wr_o(wr), .reg_wdata_o(wd), .reg_rdata_i(rdat));
    ilp_irq_log u_dut (.core_clk_i(core_clk_i), .rst_i(rst_i), .reg_addr_i(addr),
        .reg_rd_i(rd), .reg_wr_i(wr), .reg_wdata_i(wd), .reg_rdata_o(rdat),
        .terminal_soft_reset_i(srst), .rt_event_i(rt_ev), .rt_enable_i(rt_en),
        .rt_out_enable_i(rt_oe), .rt_desc_addr_i(rt_da), .hw_event_i(hw_ev),
        .ram_parity_fail_i(pf), .ram_parity_addr_i(pa), .log_we_o(we),
        .log_addr_o(la), .log_data_o(ld), .irq_n_o(irq_n));
    // verdict
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // word compare
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        cmp_count++;
        if (g !== e) begin
            fail_count++;
            $display("ERROR %0t got %h expected %h", $time, g, e);
        end
    endtask
    // register read with expected value
    task automatic rc(input logic [15:0] a, input logic [15:0] e);
        u_host.rd(a, v);
        chk(v, e);
    endtask
    // one event pulse, then both log words checked, or no log write when id is zero
    task automatic ev(input logic [15:0] h, input logic [15:0] r, input logic [15:0] id,
                      input logic [15:0] aw);
        @(posedge core_clk_i) #1;
        hw_ev = h;
        rt_ev = r;
        @(posedge core_clk_i) #1;
        hw_ev = 16'h0000;
        rt_ev = 16'h0000;
        if (id === 16'h0000) begin
            chk({15'h0000, we}, 16'h0000);
        end else begin
            chk({we, la[14:0]}, {1'b1, ptr[14:0]});
            chk(ld, id);
            @(posedge core_clk_i) #1;
            chk({we, la[14:0]}, {1'b1, ptr[14:0] + 15'h0001});
            chk(ld, aw);
            ptr = (ptr == 16'h01BE) ? 16'h0180 : ptr + 16'h0002;
        end
    endtask
    // watchdog
    initial begin
        #20000;
        fail_count++;
        close_out();
    end
    // main sequence
    initial begin
        hw_ev = 16'h0000;
        rt_ev = 16'h0000;
        rt_en = 16'h0020;
        rt_oe = 16'h0020;
        rt_da = 16'h0400;
        pa = 16'h0123;
        srst = 1'b0;
        pf = 1'b0;
        repeat (3) @(posedge core_clk_i);
        #1 rst_i = 1'b0;
        rc(ILP_CNTPTR_OFS, 16'h0180);
        rc(ILP_HW_EN_OFS, 16'hE008);
        rc(ILP_HW_OE_OFS, 16'h0000);
        ev(16'h1000, 16'h0000, 16'h0000, 16'h0000);
        u_host.wr(ILP_HW_EN_OFS, 16'hF008);
        rc(ILP_HW_PEND_OFS, 16'h0000);
        u_host.wr(ILP_HW_OE_OFS, 16'h2000);
        u_host.wr(ILP_CNTPTR_OFS, 16'h0000);
        ev(16'h2000, 16'h0000, 16'h2000, 16'h0000);
        chk({15'h0000, irq_n}, 16'h0000);
        rc(ILP_HW_PEND_OFS, 16'h2000);
        @(posedge core_clk_i) #1;
        chk({15'h0000, irq_n}, 16'h0001);
        rc(ILP_HW_PEND_OFS, 16'h0000);
        rc(ILP_CNTPTR_OFS, 16'h0382);
        rc(ILP_CNTPTR_OFS, 16'h0182);
        ev(16'h6000, 16'h0000, 16'h6000, 16'h0000);
        rc(ILP_HW_PEND_OFS, 16'h6000);
        ev(16'h1000, 16'h0000, 16'h1000, 16'h0000);
        chk({15'h0000, irq_n}, 16'h0001);
        pf = 1'b1;
        ev(16'h0008, 16'h0000, 16'h0008, 16'h0123);
        pf = 1'b0;
        ev(16'h0000, 16'h0020, 16'h0024, 16'h0400);
        chk({15'h0000, irq_n}, 16'h0000);
        rc(ILP_HW_PEND_OFS, 16'h1008 | 16'h0004);
        rc(ILP_RT_PEND_OFS, 16'h0020);
        rc(ILP_RT_PEND_OFS, 16'h0000);
        @(posedge core_clk_i) #1;
        chk({15'h0000, irq_n}, 16'h0001);
        srst = 1'b1;
        @(posedge core_clk_i) #1;
        srst = 1'b0;
        rc(ILP_CNTPTR_OFS, 16'h098A);
        repeat (27) ev(16'h2000, 16'h0000, 16'h2000, 16'h0000);
        rc(ILP_CNTPTR_OFS, 16'h3780);
        repeat (130) ev(16'h2000, 16'h0000, 16'h2000, 16'h0000);
        rc(ILP_CNTPTR_OFS, 16'hFE00 | ptr);
        // second master reset in mid-run
        rst_i = 1'b1;
        repeat (3) @(posedge core_clk_i);
        #1 rst_i = 1'b0;
        ptr = 16'h0180;
        chk({15'h0000, irq_n}, 16'h0001);
        rc(ILP_HW_EN_OFS, 16'hE008);
        rc(ILP_CNTPTR_OFS, 16'h0180);
        ev(16'h2000, 16'h0000, 16'h2000, 16'h0000);
        ev(16'h8000, 16'h0000, 16'h8000, 16'h0000);
        rc(ILP_CNTPTR_OFS, 16'h0584);
        close_out();
    end
endmodule
`default_nettype wire
